// >>> pkg/adc_sel_pkg.sv
// constants for the converter input select and result format block
// assumes a 32-bit apb slave with byte addresses and a 20 mhz pclk
package adc_sel_pkg;
  localparam logic [7:0] input_select_offset = 8'h7c;
  localparam logic [7:0] result_low_offset = 8'h78;
  localparam logic [7:0] result_high_offset = 8'h79;
  // byte addresses of the word-aligned registers (offsets not all multiples of four)
  localparam logic [11:0] addr_input_select = 12'h1f0;
  localparam logic [11:0] addr_result_low = 12'h1e0;
  localparam logic [11:0] addr_result_high = 12'h1e4;
  localparam logic [11:0] addr_status = 12'h200;
  localparam logic [11:0] addr_mask = 12'h204;
  localparam logic [7:0] input_select_reset = 8'h00;
  localparam int ref_hi = 7;
  localparam int ref_lo = 6;
  localparam int align_bit = 5;
  localparam int chan_hi = 4;
  localparam int result_width = 10;
  localparam int status_done_bit = 0;
  typedef enum logic [1:0] {
    ref_external = 2'h0,
    ref_supply = 2'h1,
    ref_internal_1v1 = 2'h2,
    ref_internal_2v56 = 2'h3
  } reference_t;
  typedef enum logic [1:0] {
    gain_none = 2'h0,
    gain_x1 = 2'h1,
    gain_x10 = 2'h2,
    gain_x200 = 2'h3
  } gain_t;
  typedef enum logic [1:0] {
    conv_idle = 2'b00,
    conv_busy = 2'b01
  } conv_state_t;
  localparam logic [3:0] input_bandgap = 4'h8;
  localparam logic [3:0] input_ground = 4'h9;
endpackage : adc_sel_pkg

// >>> core/adc_channel_decode.sv
// decodes the 5-bit channel and gain code into analog routing
// assumes the latched code is stable for the whole conversion
module adc_channel_decode
(
  input wire logic [4:0] channel_gain_select,
  output logic [3:0] positive_input,
  output logic [3:0] negative_input,
  output logic differential,
  output adc_sel_pkg::gain_t gain
);
  import adc_sel_pkg::*;
  wire is_single = (channel_gain_select[4:3] == 2'h0);
  wire is_gained = (channel_gain_select[4:3] == 2'h1);
  wire is_special = (channel_gain_select[4:1] == 4'hf);
  wire [3:0] gained_pos = {3'h0, channel_gain_select[0]} + (channel_gain_select[2] ? 4'h2 : 4'h0);
  wire [3:0] gained_neg = channel_gain_select[2] ? 4'h2 : 4'h0;
  wire [3:0] unity_pos_b = {1'h0, channel_gain_select[2:0]};
  wire [3:0] unity_neg = channel_gain_select[3] ? 4'h2 : 4'h1;
  always_comb
  begin
    positive_input = {1'h0, channel_gain_select[2:0]};
    negative_input = 4'h0;
    differential = 1'b0;
    gain = gain_none;
    if (is_special)
    begin
      positive_input = channel_gain_select[0] ? input_ground : input_bandgap;
    end
    else if (is_gained)
    begin
      positive_input = gained_pos;
      negative_input = gained_neg;
      differential = 1'b1;
      gain = channel_gain_select[1] ? gain_x200 : gain_x10;
    end
    else if (!is_single)
    begin
      positive_input = unity_pos_b;
      negative_input = unity_neg;
      differential = 1'b1;
      gain = gain_x1;
    end
  end
endmodule : adc_channel_decode

// >>> core/adc_input_select.sv
// input select register, result formatting and done flag behind apb
// assumes the analog core pulses conv_done with conv_code for one cycle
module adc_input_select
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [9:0] conv_code,
  output adc_sel_pkg::reference_t reference_select,
  output logic [3:0] positive_input,
  output logic [3:0] negative_input,
  output logic differential,
  output adc_sel_pkg::gain_t gain,
  output logic conversion_done_flag,
  output logic irq
);
  import adc_sel_pkg::*;

  logic [7:0] converter_input_select;
  logic [9:0] result;
  logic result_frozen;
  logic done_mask;
  logic [1:0] active_ref;
  logic [4:0] active_chan;
  conv_state_t state;
  logic [31:0] next_prdata;

  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire hit_sel = (paddr == addr_input_select);
  wire hit_low = (paddr == addr_result_low);
  wire hit_high = (paddr == addr_result_high);
  wire hit_stat = (paddr == addr_status);
  wire hit_mask = (paddr == addr_mask);
  wire hit_any = hit_sel || hit_low || hit_high || hit_stat || hit_mask;
  wire left_align_result = converter_input_select[align_bit];
  wire [4:0] channel_gain_select = converter_input_select[chan_hi:0];
  wire [1:0] ref_field = converter_input_select[ref_hi:ref_lo];
  wire done_clear = wr && hit_stat && pwdata[status_done_bit];
  // result updates unless the low byte was read and the high byte still pending
  wire result_load = conv_done && !result_frozen;
  wire [7:0] result_low_byte = left_align_result ? {result[1:0], 6'h00}
                                                 : result[7:0];
  wire [7:0] result_high_byte = left_align_result ? result[9:2]
                                                  : {6'h00, result[9:8]};
  wire result_sign_bit = result[result_width - 1];

  assign pready = 1'b1;
  assign pslverr = access && !hit_any;
  assign irq = conversion_done_flag && done_mask;
  assign reference_select = reference_t'(active_ref);

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit_sel)
      next_prdata = {24'h00_0000, converter_input_select};
    else if (hit_low)
      next_prdata = {24'h00_0000, result_low_byte};
    else if (hit_high)
      next_prdata = {24'h00_0000, result_high_byte};
    else if (hit_stat)
      next_prdata = {31'h0000_0000, conversion_done_flag};
    else if (hit_mask)
      next_prdata = {31'h0000_0000, done_mask};
  end
  assign prdata = next_prdata;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      converter_input_select <= input_select_reset;
    else if (wr && hit_sel)
      converter_input_select <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_mask <= 1'b0;
    else if (wr && hit_mask)
      done_mask <= pwdata[status_done_bit];
  end

  // raw code stored unchanged: unsigned or two's complement as the core delivers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result <= 10'h000;
    else if (result_load)
      result <= conv_code;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_frozen <= 1'b0;
    else if (rd && hit_high)
      result_frozen <= 1'b0;
    else if (rd && hit_low)
      result_frozen <= 1'b1;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conversion_done_flag <= 1'b0;
    else if (result_load)
      conversion_done_flag <= 1'b1;
    else if (done_clear)
      conversion_done_flag <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= conv_idle;
    else
    begin
      case (state)
        conv_idle:
        begin
          if (conv_start)
            state <= conv_busy;
        end
        conv_busy:
        begin
          if (conv_done)
            state <= conv_idle;
        end
        default:
        begin
          state <= conv_idle;
        end
      endcase
    end
  end

  // selection only follows the register while no conversion runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_ref <= 2'h0;
      active_chan <= 5'h00;
    end
    else if (state == conv_idle && !conv_start)
    begin
      active_ref <= ref_field;
      active_chan <= channel_gain_select;
    end
  end

  adc_channel_decode u_decode
  (
    .channel_gain_select(active_chan),
    .positive_input(positive_input),
    .negative_input(negative_input),
    .differential(differential),
    .gain(gain)
  );

  hold_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == conv_busy) |=> $stable(active_ref) && $stable(active_chan))
    else $error("selection changed during conversion");
  flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    result_load |=> conversion_done_flag && result == $past(conv_code))
    else $error("done flag or result not updated");
  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    done_clear && !result_load |=> !conversion_done_flag)
    else $error("done flag not cleared");
  freeze_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    result_frozen && !(rd && hit_high) |=> $stable(result))
    else $error("result changed while frozen");
  freeze_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && hit_low && !hit_high |=> result_frozen)
    else $error("low read did not freeze result");
  left_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    left_align_result |-> result_high_byte == result[9:2]
      && result_low_byte[7:6] == result[1:0])
    else $error("left aligned mapping wrong");
  right_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    !left_align_result |-> result_high_byte == {6'h00, result[9:8]}
      && result_low_byte == result[7:0])
    else $error("right aligned mapping wrong");
  align_now_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_sel && pwdata[align_bit] |=> result_high_byte == result[9:2])
    else $error("align change not immediate");
  sign_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    left_align_result |-> result_high_byte[7] == result_sign_bit)
    else $error("sign bit misplaced");
  irq_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == (conversion_done_flag && done_mask))
    else $error("interrupt level wrong");

  ref_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |-> reference_select == reference_t'(active_ref))
    else $error("reference output differs from latched field");

  sel_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == conv_idle && !conv_start
    |=> active_ref == $past(ref_field) && active_chan == $past(channel_gain_select))
    else $error("idle selection did not follow register");

  start_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == conv_idle && conv_start
    |=> state == conv_busy && $stable(active_ref) && $stable(active_chan))
    else $error("selection not latched at start");

  busy_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == conv_busy && conv_done
    |=> state == conv_idle)
    else $error("conversion did not end on done");

  frozen_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && result_frozen && !done_clear
    |=> conversion_done_flag == $past(conversion_done_flag))
    else $error("frozen result still touched the flag");

  high_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && hit_high
    |=> !result_frozen)
    else $error("high byte read did not release result");

  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    result_load && done_clear
    |=> conversion_done_flag)
    else $error("clear beat a new result");

  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !result_load && !done_clear
    |=> $stable(conversion_done_flag))
    else $error("done flag moved without cause");

  load_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    !result_load
    |=> $stable(result))
    else $error("result changed without a load");

  left_low_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    left_align_result
    |-> result_low_byte[5:0] == 6'h00)
    else $error("left aligned low byte not padded");

  right_high_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    !left_align_result
    |-> result_high_byte[7:2] == 6'h00)
    else $error("right aligned high byte not padded");

  sign_right_a: assert property (@(posedge pclk) disable iff (!presetn)
    !left_align_result
    |-> result_high_byte[1] == result_sign_bit)
    else $error("right aligned sign bit misplaced");

  sel_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_sel
    |=> converter_input_select == $past(pwdata[7:0]))
    else $error("select register write lost");

  read_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && hit_low
    |-> prdata == {24'h00_0000, result_low_byte})
    else $error("low byte read wrong");

  read_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && hit_high
    |-> prdata == {24'h00_0000, result_high_byte})
    else $error("high byte read wrong");

  read_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && hit_sel
    |-> prdata[7:0] == converter_input_select)
    else $error("select register read wrong");

  single_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    active_chan[4:3] == 2'h0
    |-> !differential && gain == gain_none && negative_input == 4'h0)
    else $error("single-ended routing wrong");

  gained_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    active_chan[4:3] == 2'h1
    |-> differential && (gain == gain_x10 || gain == gain_x200))
    else $error("gained pair routing wrong");

  unity_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    active_chan[4] && active_chan[4:1] != 4'hf
    |-> differential && gain == gain_x1)
    else $error("unity pair routing wrong");

  fixed_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    active_chan[4:1] == 4'hf
    |-> !differential && positive_input == (active_chan[0] ? input_ground : input_bandgap))
    else $error("bandgap or ground routing wrong");

  irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    !done_mask
    |-> !irq)
    else $error("masked interrupt raised");

  conv_cycle_c: cover property (@(posedge pclk) disable iff (!presetn)
    conv_start ##[1:100] conv_done);
  frozen_drop_c: cover property (@(posedge pclk) disable iff (!presetn)
    result_frozen && conv_done);
  set_clear_c: cover property (@(posedge pclk) disable iff (!presetn)
    result_load && done_clear);
  busy_write_c: cover property (@(posedge pclk) disable iff (!presetn)
    state == conv_busy && wr && hit_sel);
  frozen_align_c: cover property (@(posedge pclk) disable iff (!presetn)
    result_frozen && wr && hit_sel);
endmodule : adc_input_select

// >>> verification/adc_core_model.sv
// model of the analog converter core on the far side of the block
// assumes one pclk domain; req starts a conversion of req_len cycles
module adc_core_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic [9:0] req_code,
  input wire logic [3:0] req_len,
  output logic conv_start,
  output logic conv_done,
  output logic [9:0] conv_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic [9:0] held;
  // code is only valid with the done pulse; otherwise it shows garbage
  assign conv_code = conv_done ? held : ~held;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 4'h0;
      conv_start <= 1'b0;
      conv_done <= 1'b0;
      held <= 10'h000;
    end
    else
    begin
      conv_start <= req && cnt == 4'h0;
      conv_done <= cnt == 4'h1;
      if (req && cnt == 4'h0)
      begin
        cnt <= req_len;
        held <= req_code;
      end
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
    end
  end
endmodule : adc_core_model

// >>> verification/tb_top.sv
// self-checking bench for the input select and result format block
// assumes a 20 mhz pclk and the apb map of adc_sel_pkg
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_sel_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, slverr, req = 1'b0, conv_start, conv_done;
  logic differential, conversion_done_flag, irq;
  logic [9:0] req_code = 10'h000, conv_code;
  logic [3:0] req_len = 4'h3, positive_input, negative_input;
  logic [1:0] r;
  reference_t reference_select;
  gain_t gain;
  int err_total = 0, check_count = 0;
  adc_input_select i_adc_input_select (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_start(conv_start), .conv_done(conv_done),
    .conv_code(conv_code), .reference_select(reference_select), .positive_input(positive_input),
    .negative_input(negative_input), .differential(differential), .gain(gain),
    .conversion_done_flag(conversion_done_flag), .irq(irq));
  adc_core_model i_adc_core_model (.pclk(pclk), .presetn(presetn), .req(req),
    .req_code(req_code), .req_len(req_len), .conv_start(conv_start), .conv_done(conv_done),
    .conv_code(conv_code));
  initial
  begin
    forever #25 pclk = ~pclk;
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      err_total++;
      print_verdict();
    end
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic settle;
    repeat (2) @(negedge pclk);
  endtask : settle
  task automatic go(input logic [9:0] code, input logic [3:0] len);
    @(posedge pclk);
    req <= 1'b1;
    req_code <= code;
    req_len <= len;
    @(posedge pclk);
    req <= 1'b0;
  endtask : go
  task automatic fin;
    int n;
    n = 0;
    while (conv_done !== 1'b1 && n < 40)
    begin
      @(negedge pclk);
      n++;
    end
    if (n == 40)
    begin
      err_total++;
      print_verdict();
    end
    settle();
  endtask : fin
  // expected {diff, gain, positive, negative} for a channel code
  function automatic logic [10:0] dec(input logic [4:0] c);
    if (c < 8)
      return {1'b0, gain_none, 1'b0, c[2:0], 4'h0};
    if (c < 16)
      return {1'b1, c[1] ? gain_x200 : gain_x10, 2'b0, c[2], c[0], 2'b0, c[2], 1'b0};
    if (c < 30)
      return {1'b1, gain_x1, 1'b0, c[2:0], c < 24 ? 4'h1 : 4'h2};
    return {1'b0, gain_none, c[0] ? input_ground : input_bandgap, 4'h0};
  endfunction : dec
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(addr_input_select, 32'h0);
    rd(addr_result_high, 32'h0);
    for (int c = 0; c < 32; c++)
    begin
      // gained pairs only with the 2.56v reference
      r = (c >= 8 && c < 16) ? 2'h3 : 2'(c);
      apb(1'b1, addr_input_select, {24'h0, r, 1'b0, 5'(c)});
      settle();
      chk(32'(reference_select), 32'(r));
      chk(32'({differential, gain, positive_input, differential ? negative_input : 4'h0}),
        32'(dec(5'(c))));
    end
    apb(1'b1, addr_input_select, 32'hed);
    settle();
    go(10'h270, 4'hc);
    apb(1'b1, addr_input_select, 32'h61);
    settle();
    chk(32'(reference_select), 32'h3);
    chk(32'(positive_input), 32'h3);
    fin();
    chk(32'(conversion_done_flag), 32'h1);
    chk(32'(reference_select), 32'h1);
    rd(addr_result_low, 32'h00);
    rd(addr_result_high, 32'h9c);
    chk(32'(q[7]), 32'h1);
    apb(1'b1, addr_input_select, 32'h41);
    rd(addr_result_low, 32'h70);
    rd(addr_result_high, 32'h02);
    apb(1'b1, addr_mask, 32'h1);
    @(negedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, addr_status, 32'h1);
    @(negedge pclk);
    chk(32'({irq, conversion_done_flag}), 32'h0);
    rd(addr_result_low, 32'h70);
    go(10'h155, 4'h3);
    fin();
    rd(addr_result_high, 32'h02);
    chk(32'(conversion_done_flag), 32'h0);
    go(10'h3ff, 4'h3);
    fin();
    rd(addr_result_low, 32'hff);
    rd(addr_result_high, 32'h03);
    rd(addr_status, 32'h1);
    apb(1'b1, addr_mask, 32'h0);
    @(negedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b1, 12'h100, 32'hff);
    chk(32'(slverr), 32'h1);
    rd(addr_input_select, 32'h41);
    print_verdict();
  end
endmodule : tb_top
